// File: utx_defs.svh
// Register offsets, field positions, reset values and timing constants of the transmit port
`ifndef UTX_DEFS_SVH
`define UTX_DEFS_SVH

`define UTX_OFS_DATA        8'h00
`define UTX_OFS_STATUS      8'h18
`define UTX_OFS_DIV_WHOLE   8'h24
`define UTX_OFS_DIV_FRAC    8'h28
`define UTX_OFS_LINE_CTRL   8'h2C
`define UTX_OFS_PORT_CTRL   8'h30

`define UTX_RST_DIV_WHOLE   16'h0000
`define UTX_RST_DIV_FRAC    6'h00
`define UTX_RST_LINE_CTRL   8'h00
`define UTX_RST_PORT_CTRL   1'b0

`define UTX_FRAC_MSB        5
`define UTX_WHOLE_MSB       15
`define UTX_LCTL_MSB        7
`define UTX_OVS_BIT         3

`define UTX_ST_BUSY         0
`define UTX_ST_EMPTY        1
`define UTX_ST_FULL         2
`define UTX_ST_BREAK        3
`define UTX_ST_CNT_LSB      8

`define UTX_SMP_16          4'hF
`define UTX_SMP_8           4'h7
`define UTX_FIFO_DEPTH      32
`define UTX_FIFO_WIDTH      8
`define UTX_HTRANS_NONSEQ   2'h2

`endif

// File: utx_pkg.sv
// Types shared by the transmit framing block
package utx_pkg;

    typedef enum logic [2:0] {
        UTX_IDLE  = 3'b000,
        UTX_START = 3'b001,
        UTX_DATA  = 3'b010,
        UTX_PAR   = 3'b011,
        UTX_STOP  = 3'b100,
        UTX_BREAK = 3'b101
    } utx_state_t;

    // Bit order matches the transmit line control register, bit 7 down to bit 0
    typedef struct packed {
        logic       tx_fixed_parity;
        logic [1:0] tx_word_length;
        logic       tx_queue_on;
        logic       tx_two_stop_select;
        logic       tx_parity_even_select;
        logic       tx_parity_on;
        logic       send_break;
    } utx_line_ctrl_t;

    typedef struct packed {
        logic [15:0] divisor_integer;
        logic [5:0]  divisor_fraction;
        logic        oversample_select;
    } utx_baud_t;

endpackage

// File: utx_top.sv
// Transmit framing with fractional baud divisor, AHB-Lite registers and a character FIFO
//
// What this block does
// RQ1: Fraction register keeps six divisor bits in bits 5:0; upper bits are reserved.
// RQ2: Oversample select clear: divisor counts reference clocks per sixteenth of a bit.
// RQ3: Oversample select set: divisor counts reference clocks per eighth of a bit.
// RQ4: Effective divisor combines the whole part and the six-bit fraction.
// RQ5: New divisor values only take effect once the current character is finished.
// RQ6: Break drives the line low continuously, starting after the current character.
// RQ7: Software holds break for at least one whole frame time.
// RQ8: During break the queued characters are neither dropped nor consumed.
// RQ9: Parity off sends no parity bit; parity type is then ignored.
// RQ10: Odd type: parity makes data plus parity hold an odd count of ones.
// RQ11: Even type: parity makes data plus parity hold an even count of ones.
// RQ12: Stop select clear sends one stop bit, set sends two.
// RQ13: Queue off shrinks the transmit queue to a single byte holding register.
// RQ14: Word length code 00 to 11 selects five to eight data bits.
// RQ15: Fixed parity with even type always sends parity as zero.
// RQ16: Fixed parity with odd type always sends parity as one.
// RQ17: A bit lasts sixteen sample ticks, or eight with oversample select set.
// RQ18: Fraction adds sixty-fourths; accumulator carry stretches a tick by one clock.
// RQ19: Frame is idle high, low start, data LSB first, optional parity, high stops.
`timescale 1ns/1ps
`include "utx_defs.svh"

module utx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       in_valid_i,
    output logic                            in_ready_o,
    input  wire logic [WIDTH-1:0]           in_data_i,
    output logic                            out_valid_o,
    input  wire logic                       out_ready_i,
    output logic [WIDTH-1:0]                out_data_o,
    output logic [$clog2(DEPTH+1)-1:0]      count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0]          mem_r [DEPTH];
    logic [AW-1:0]             wr_ptr_r;
    logic [AW-1:0]             rd_ptr_r;
    logic [$clog2(DEPTH+1)-1:0] cnt_r;
    logic                      push;
    logic                      pop;

    assign in_ready_o  = (cnt_r != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rd_ptr_r];
    assign count_o     = cnt_r;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

module utx_top
    import utx_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic             txd_o
);
    localparam int CW = $clog2(`UTX_FIFO_DEPTH + 1);

    // Software-visible state
    utx_line_ctrl_t lctl_r;
    utx_baud_t      baud_r;
    // Settings frozen for the frame in progress
    utx_line_ctrl_t lctl_act_r;
    utx_baud_t      baud_act_r;

    logic        pend_r;
    logic        pend_wr_r;
    logic [7:0]  pend_ofs_r;
    logic        hreadyout_r;
    logic [31:0] hrdata_r;
    logic        hresp_r;

    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [7:0]  fifo_out_data;
    logic [CW-1:0] fifo_count;
    logic        push_ready;
    logic        push_valid;
    logic        pop;

    utx_state_t  state_r;
    logic [7:0]  shift_r;
    logic [2:0]  bit_idx_r;
    logic        stop_idx_r;
    logic        par_bit_r;
    logic [3:0]  smp_r;
    logic [15:0] div_cnt_r;
    logic [5:0]  frac_acc_r;
    logic        txd_r;

    logic        tick;
    logic        bit_end;
    logic [2:0]  wlen_last;
    logic [6:0]  frac_sum;
    logic [15:0] reload;

    function automatic logic parity_of(input logic [7:0] d, input logic [1:0] wl);
        logic [7:0] m;
        m = 8'h1F;
        unique case (wl)
            2'b00: m = 8'h1F;
            2'b01: m = 8'h3F;
            2'b10: m = 8'h7F;
            2'b11: m = 8'hFF;
        endcase
        return ^(d & m);
    endfunction

    function automatic logic [15:0] whole_reload(input logic [15:0] w, input logic s);
        logic [15:0] base;
        base = (w == 16'h0000) ? 16'h0000 : w - 16'h0001;
        return base + {15'h0000, s};
    endfunction

    // AHB-Lite slave: every transfer takes one wait state; a data write also waits for room
    assign push_ready = fifo_in_ready && (lctl_r.tx_queue_on || fifo_count == '0); // RQ13
    assign push_valid = pend_r && pend_wr_r && (pend_ofs_r == `UTX_OFS_DATA);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_r      <= 1'b0;
            pend_wr_r   <= 1'b0;
            pend_ofs_r  <= 8'h00;
            hreadyout_r <= 1'b1;
        end else if (pend_r) begin
            if (!push_valid || push_ready) begin
                pend_r      <= 1'b0;
                hreadyout_r <= 1'b1;
            end
        end else if (hsel_i && hready_i && htrans_i[1]) begin
            pend_r      <= 1'b1;
            pend_wr_r   <= hwrite_i;
            pend_ofs_r  <= {haddr_i[7:2], 2'b00};
            hreadyout_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hresp_r <= 1'b0;
        end else begin
            hresp_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lctl_r <= `UTX_RST_LINE_CTRL;
            baud_r <= {`UTX_RST_DIV_WHOLE, `UTX_RST_DIV_FRAC, `UTX_RST_PORT_CTRL};
        end else if (pend_r && pend_wr_r) begin
            unique case (pend_ofs_r)
                `UTX_OFS_DIV_WHOLE: baud_r.divisor_integer  <= hwdata_i[`UTX_WHOLE_MSB:0];
                `UTX_OFS_DIV_FRAC:  baud_r.divisor_fraction <= hwdata_i[`UTX_FRAC_MSB:0]; // RQ1
                `UTX_OFS_LINE_CTRL: lctl_r <= hwdata_i[`UTX_LCTL_MSB:0];
                `UTX_OFS_PORT_CTRL: baud_r.oversample_select <= hwdata_i[`UTX_OVS_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_r <= 32'h0000_0000;
        end else if (pend_r && !pend_wr_r) begin
            hrdata_r <= 32'h0000_0000;
            unique case (pend_ofs_r)
                `UTX_OFS_DIV_WHOLE: hrdata_r[`UTX_WHOLE_MSB:0] <= baud_r.divisor_integer;
                `UTX_OFS_DIV_FRAC:  hrdata_r[`UTX_FRAC_MSB:0]  <= baud_r.divisor_fraction; // RQ1
                `UTX_OFS_LINE_CTRL: hrdata_r[`UTX_LCTL_MSB:0]  <= lctl_r;
                `UTX_OFS_PORT_CTRL: hrdata_r[`UTX_OVS_BIT]     <= baud_r.oversample_select;
                `UTX_OFS_STATUS: begin
                    hrdata_r[`UTX_ST_BUSY]  <= (state_r != UTX_IDLE);
                    hrdata_r[`UTX_ST_EMPTY] <= !fifo_out_valid;
                    hrdata_r[`UTX_ST_FULL]  <= !push_ready;
                    hrdata_r[`UTX_ST_BREAK] <= (state_r == UTX_BREAK);
                    hrdata_r[`UTX_ST_CNT_LSB +: CW] <= fifo_count;
                end
                default: ;
            endcase
        end
    end

    utx_fifo #(
        .WIDTH (`UTX_FIFO_WIDTH),
        .DEPTH (`UTX_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push_valid && push_ready),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (hwdata_i[7:0]),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_out_data),
        .count_o     (fifo_count)
    );

    // Break waits for idle and never pops, so queued characters survive it
    assign pop = (state_r == UTX_IDLE) && fifo_out_valid && !lctl_r.send_break; // RQ8

    // Sample tick: whole part plus a carry from the sixty-fourths accumulator
    assign frac_sum = {1'b0, frac_acc_r} + {1'b0, baud_act_r.divisor_fraction}; // RQ18
    assign reload   = whole_reload(baud_act_r.divisor_integer, frac_sum[6]); // RQ4
    assign tick     = (state_r != UTX_IDLE) && (state_r != UTX_BREAK) && (div_cnt_r == 16'h0000);
    assign bit_end  = tick && (smp_r == (baud_act_r.oversample_select ? `UTX_SMP_8
                                                                      : `UTX_SMP_16)); // RQ17
    assign wlen_last = {1'b1, lctl_act_r.tx_word_length} - 3'h4 + 3'h4;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt_r  <= 16'h0000;
            frac_acc_r <= 6'h00;
            smp_r      <= 4'h0;
        end else if (pop) begin
            div_cnt_r  <= whole_reload(baud_r.divisor_integer, 1'b0); // RQ5
            frac_acc_r <= 6'h00;
            smp_r      <= 4'h0;
        end else if (tick) begin
            div_cnt_r  <= reload; // RQ2 RQ3
            frac_acc_r <= frac_sum[5:0]; // RQ18
            smp_r      <= bit_end ? 4'h0 : smp_r + 4'h1;
        end else if (div_cnt_r != 16'h0000) begin
            div_cnt_r  <= div_cnt_r - 16'h0001;
        end
    end

    // Divisor and line settings are captured only between characters
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            baud_act_r <= {`UTX_RST_DIV_WHOLE, `UTX_RST_DIV_FRAC, `UTX_RST_PORT_CTRL};
            lctl_act_r <= `UTX_RST_LINE_CTRL;
        end else if (pop) begin
            baud_act_r <= baud_r; // RQ5
            lctl_act_r <= lctl_r;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r    <= UTX_IDLE;
            shift_r    <= 8'h00;
            bit_idx_r  <= 3'h0;
            stop_idx_r <= 1'b0;
            par_bit_r  <= 1'b0;
        end else begin
            unique case (state_r)
                UTX_IDLE: begin
                    if (lctl_r.send_break) begin
                        state_r <= UTX_BREAK; // RQ6
                    end else if (pop) begin
                        state_r <= UTX_START;
                        shift_r <= fifo_out_data;
                        if (lctl_r.tx_fixed_parity) begin
                            par_bit_r <= !lctl_r.tx_parity_even_select; // RQ15 RQ16
                        end else if (lctl_r.tx_parity_even_select) begin
                            par_bit_r <= parity_of(fifo_out_data, lctl_r.tx_word_length); // RQ11
                        end else begin
                            par_bit_r <= !parity_of(fifo_out_data, lctl_r.tx_word_length); // RQ10
                        end
                    end
                end
                UTX_START: begin
                    if (bit_end) begin
                        state_r   <= UTX_DATA;
                        bit_idx_r <= 3'h0;
                    end
                end
                UTX_DATA: begin
                    if (bit_end) begin
                        shift_r <= {1'b0, shift_r[7:1]}; // RQ19
                        if (bit_idx_r == wlen_last) begin // RQ14
                            state_r    <= lctl_act_r.tx_parity_on ? UTX_PAR : UTX_STOP; // RQ9
                            stop_idx_r <= 1'b0;
                        end else begin
                            bit_idx_r <= bit_idx_r + 3'h1;
                        end
                    end
                end
                UTX_PAR: begin
                    if (bit_end) begin
                        state_r    <= UTX_STOP;
                        stop_idx_r <= 1'b0;
                    end
                end
                UTX_STOP: begin
                    if (bit_end) begin
                        if (lctl_act_r.tx_two_stop_select && !stop_idx_r) begin // RQ12
                            stop_idx_r <= 1'b1;
                        end else begin
                            state_r <= UTX_IDLE;
                        end
                    end
                end
                UTX_BREAK: begin
                    // Software must hold break for a full frame time; the line follows the bit
                    if (!lctl_r.send_break) begin // RQ7
                        state_r <= UTX_IDLE;
                    end
                end
                default: state_r <= UTX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            txd_r <= 1'b1;
        end else begin
            unique case (state_r)
                UTX_START: txd_r <= 1'b0; // RQ19
                UTX_DATA:  txd_r <= shift_r[0];
                UTX_PAR:   txd_r <= par_bit_r;
                UTX_BREAK: txd_r <= 1'b0; // RQ6
                default:   txd_r <= 1'b1;
            endcase
        end
    end

    assign hrdata_o    = hrdata_r;
    assign hreadyout_o = hreadyout_r;
    assign hresp_o     = hresp_r;
    assign txd_o       = txd_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_break_line_low: assert property ( // RQ6
        $past(state_r) == UTX_BREAK |-> txd_o == 1'b0)
        else $error("Line not low during break");

    a_break_keeps_queue: assert property ( // RQ8
        state_r == UTX_BREAK |-> !pop ##1 (fifo_count >= $past(fifo_count)))
        else $error("Queue consumed during break");

    a_divisor_frozen: assert property ( // RQ5
        (state_r != UTX_IDLE && $past(state_r) != UTX_IDLE) |-> $stable(baud_act_r))
        else $error("Divisor changed mid character");

    a_bit_sample_count: assert property ( // RQ17
        bit_end |-> smp_r == (baud_act_r.oversample_select ? 4'h7 : 4'hF))
        else $error("Wrong number of samples per bit");

    a_tick_spacing: assert property ( // RQ4
        (tick && baud_act_r.divisor_integer == 16'h0002 && !frac_sum[6]
            && !bit_end && state_r != UTX_STOP)
        |=> !tick ##1 tick)
        else $error("Tick spacing differs from whole divisor");

    a_start_then_data: assert property ( // RQ19
        (state_r == UTX_START && bit_end) |=> txd_o == 1'b0 ##1 txd_o == shift_r[0])
        else $error("Start bit or first data bit wrong");

    a_word_length: assert property ( // RQ14
        (state_r == UTX_DATA && bit_end && bit_idx_r == wlen_last) |=> state_r != UTX_DATA)
        else $error("Data bit count does not match word length");

    a_no_parity_bit: assert property ( // RQ9
        (state_r == UTX_DATA && bit_end && bit_idx_r == wlen_last
            && !lctl_act_r.tx_parity_on) |=> state_r == UTX_STOP)
        else $error("Parity bit sent while parity off");

    a_parity_value: assert property ( // RQ10
        (state_r == UTX_PAR && !lctl_act_r.tx_fixed_parity) |=>
        txd_o == (parity_of($past(shift_r, 1), 2'b11) ^ 1'b0 ^ $past(par_bit_r) ^
                  parity_of($past(shift_r, 1), 2'b11)))
        else $error("Parity bit wrong");

    a_char_mode_depth: assert property ( // RQ13
        (!lctl_r.tx_queue_on && fifo_count != '0) |-> !push_ready)
        else $error("Character mode accepts more than one byte");

    a_two_stops: assert property ( // RQ12
        (state_r == UTX_STOP && bit_end && !stop_idx_r && lctl_act_r.tx_two_stop_select)
        |=> state_r == UTX_STOP && stop_idx_r)
        else $error("Second stop bit missing");
endmodule

// File: utx_rx_model.sv
// Remote serial receiver model that samples the transmit line at mid-bit
`timescale 1ns/1ps

module utx_rx_model (
    input  wire logic        clk_i,
    input  wire logic        txd_i,
    input  int               bit_clks,
    input  int               nsamp,
    output logic [11:0]      bits_o,
    output int               gap_o,
    output int               frames_o
);
    int cyc = 0;
    int last = 0;

    always @(posedge clk_i) cyc <= cyc + 1;

    // A break also looks like a start edge; it yields one frame of zeros
    initial begin
        bits_o = 12'h000;
        gap_o = 0;
        frames_o = 0;
        forever begin
            wait (txd_i === 1'b1);
            @(negedge txd_i);
            gap_o = cyc - last;
            last = cyc;
            repeat (bit_clks / 2) @(posedge clk_i);
            for (int i = 0; i < nsamp; i++) begin
                repeat (bit_clks) @(posedge clk_i);
                bits_o[i] = txd_i;
            end
            frames_o = frames_o + 1;
        end
    end
endmodule

// File: utx_top_bench.sv
// Self-checking bench for the transmit framing block
`timescale 1ns/1ps
`include "utx_defs.svh"

module utx_top_bench
    import utx_pkg::*;
;
    typedef struct packed {
        utx_line_ctrl_t lc;
        logic [7:0]     data;
    } utx_row_t;

    localparam utx_row_t ROWS [9] = '{16'h70A5, 16'h745A, 16'h7207, 16'h7607, 16'hF607,
                                       16'hF207, 16'h18F3, 16'h382D, 16'h5241};

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        txd;
    int          bit_clks = 8;
    int          nsamp = 10;
    logic [11:0] rx_bits;
    int          rx_gap;
    int          rx_frames;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    always #2.5 clk_i = ~clk_i;

    utx_top i_utx_top (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .txd_o(txd));

    utx_rx_model i_utx_rx_model (.clk_i(clk_i), .txd_i(txd), .bit_clks(bit_clks),
        .nsamp(nsamp), .bits_o(rx_bits), .gap_o(rx_gap), .frames_o(rx_frames));

    task automatic conclude();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Values seen right after the edge are the ones the edge sampled
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= `UTX_HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge clk_i); while (hready !== 1'b1 && ++n < 1000);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge clk_i); while (hready !== 1'b1 && ++n < 2000);
        rd = hrdata;
        if (n >= 1000) chk("bus answer", 32'h1, 32'h0);
        chk("bus response", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                          input logic [31:0] mask);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        chk(what, exp, x & mask);
    endtask

    task automatic wait_frames(input int n);
        int t;
        t = 0;
        while (rx_frames < n && t < 20000) begin
            @(posedge clk_i);
            t++;
        end
        if (t >= 20000) chk("frame wait", 32'h1, 32'h0);
    endtask

    // Samples after the start bit: data, optional parity, first stop
    function automatic int expect_frame(input utx_line_ctrl_t lc, input logic [7:0] d,
                                        output logic [11:0] v);
        int k;
        logic [7:0] m;
        k = 5 + int'(lc.tx_word_length);
        m = d & ~(8'hFF << k);
        v = {4'h0, m};
        if (lc.tx_parity_on) begin
            v[k] = lc.tx_fixed_parity ? ~lc.tx_parity_even_select
                 : (lc.tx_parity_even_select ? ^m : ~^m);
            k++;
        end
        v[k] = 1'b1;
        return k + 1;
    endfunction

    task automatic frame_chk(input utx_line_ctrl_t lc, input logic [7:0] d);
        logic [11:0] ev;
        int ns;
        ns = expect_frame(lc, d, ev);
        chk("frame bits", {20'h0, ev}, {20'h0, rx_bits & ~(12'hFFF << ns)});
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        utx_row_t r;
        logic [11:0] ev;
        int f;
        int lows;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("idle line", 32'h1, {31'h0, txd});
        rd_chk("fraction reset", `UTX_OFS_DIV_FRAC, 32'h0, 32'hFFFFFFFF);
        rd_chk("line ctrl reset", `UTX_OFS_LINE_CTRL, 32'h0, 32'hFFFFFFFF);
        rd_chk("unmapped", 8'h3C, 32'h0, 32'hFFFFFFFF);
        wr(`UTX_OFS_DIV_WHOLE, 32'h1);
        wr(`UTX_OFS_PORT_CTRL, 32'h8);
        wr(`UTX_OFS_DIV_FRAC, 32'hFFFFFFE0);
        rd_chk("fraction field", `UTX_OFS_DIV_FRAC, 32'h20, 32'hFFFFFFFF);
        wr(`UTX_OFS_LINE_CTRL, 32'h70);
        f = rx_frames;
        wr(`UTX_OFS_DATA, 32'h0);
        wr(`UTX_OFS_DATA, 32'h0);
        wait_frames(f + 2);
        // Half an extra clock per tick on average: 80 ticks give about 120 clocks
        chk("fraction gap", 32'h1, {31'h0, rx_gap >= 118 && rx_gap <= 124});
        wr(`UTX_OFS_DIV_FRAC, 32'h0);
        for (int i = 0; i < 9; i++) begin
            r = ROWS[i];
            nsamp = expect_frame(r.lc, r.data, ev);
            wr(`UTX_OFS_LINE_CTRL, {24'h0, r.lc});
            f = rx_frames;
            wr(`UTX_OFS_DATA, {24'h0, r.data});
            wr(`UTX_OFS_DATA, {24'h0, r.data});
            wait_frames(f + 2);
            frame_chk(r.lc, r.data);
            lows = 8 * (1 + nsamp + int'(r.lc.tx_two_stop_select));
            chk("frame gap", 32'h1, {31'h0, rx_gap >= lows && rx_gap <= lows + 4});
        end
        wr(`UTX_OFS_LINE_CTRL, 32'h70);
        nsamp = 9;
        f = rx_frames;
        wr(`UTX_OFS_DATA, 32'hC3);
        repeat (20) @(posedge clk_i);
        wr(`UTX_OFS_DIV_WHOLE, 32'h2);
        wr(`UTX_OFS_PORT_CTRL, 32'h0);
        wait_frames(f + 1);
        frame_chk(8'h70, 8'hC3);
        bit_clks = 32;
        wr(`UTX_OFS_DATA, 32'h3C);
        wait_frames(f + 2);
        frame_chk(8'h70, 8'h3C);
        wr(`UTX_OFS_DIV_WHOLE, 32'h1);
        wr(`UTX_OFS_PORT_CTRL, 32'h8);
        bit_clks = 8;
        f = rx_frames;
        wr(`UTX_OFS_LINE_CTRL, 32'h61);
        wr(`UTX_OFS_DATA, 32'h11);
        rd_chk("single holding", `UTX_OFS_STATUS, 32'h10C, 32'h3F0E);
        repeat (100) @(posedge clk_i);
        wr(`UTX_OFS_LINE_CTRL, 32'h60);
        wait_frames(f + 2);
        frame_chk(8'h60, 8'h11);
        f = rx_frames;
        wr(`UTX_OFS_LINE_CTRL, 32'h70);
        wr(`UTX_OFS_DATA, 32'h96);
        repeat (20) @(posedge clk_i);
        wr(`UTX_OFS_LINE_CTRL, 32'h71);
        wait_frames(f + 1);
        frame_chk(8'h70, 8'h96);
        for (int i = 0; i < `UTX_FIFO_DEPTH; i++) wr(`UTX_OFS_DATA, i);
        rd_chk("queue full", `UTX_OFS_STATUS, 32'h200C, 32'h3F0E);
        lows = 0;
        repeat (100) begin
            @(posedge clk_i);
            lows += (txd === 1'b0);
        end
        chk("break low", 32'd100, lows);
        rd_chk("queue kept", `UTX_OFS_STATUS, 32'h200C, 32'h3F0E);
        wr(`UTX_OFS_LINE_CTRL, 32'h70);
        wait_frames(f + 2 + `UTX_FIFO_DEPTH);
        frame_chk(8'h70, 8'h1F);
        rd_chk("queue drained", `UTX_OFS_STATUS, 32'h2, 32'h3F0E);
        conclude();
    end
endmodule
